/* rtl/rscc_params.svh */
// constants for the strap-captured clock ratio configuration block
`ifndef RSCC_PARAMS_SVH
`define RSCC_PARAMS_SVH

// register byte offsets
`define RSCC_OFS_STATUS    8'h00
`define RSCC_OFS_PLAT      8'h04
`define RSCC_OFS_CORE      8'h08
`define RSCC_OFS_LDIV      8'h0C
`define RSCC_OFS_LIMIT_PLT 8'h10
`define RSCC_OFS_LIMIT_CPU 8'h14
`define RSCC_OFS_LIMIT_LBC 8'h18

// status register field positions
`define RSCC_ST_CAPTURED   0
`define RSCC_ST_PLAT_ERR   1
`define RSCC_ST_CORE_ERR   2
`define RSCC_ST_SPEED      3

// reset values and bus response codes
`define RSCC_LDIV_RST      8'h04
`define RSCC_SLVERR        2'h2
`define RSCC_OKAY          2'h0

// frequency windows in MHz
`define RSCC_PLAT_MIN_MHZ  16'h014D
`define RSCC_PLAT_MAX_MHZ  16'h0215
`define RSCC_CORE_MIN_MHZ  16'h029A
`define RSCC_CORE_MAX_MHZ  16'h0535
`define RSCC_MEM_MIN_MHZ   16'h00A6
`define RSCC_MEM_MAX_MHZ   16'h010A
`define RSCC_LBC_MIN_MHZ   16'h0016
`define RSCC_LBC_MAX_MHZ   16'h0085

// straps settle for this long after reset release before capture
`define RSCC_STRAP_SETTLE_NS 200
`define RSCC_CLK_PERIOD_NS   50
`define RSCC_SETTLE_CYC \
    ((`RSCC_STRAP_SETTLE_NS + `RSCC_CLK_PERIOD_NS - 1) / `RSCC_CLK_PERIOD_NS)

`endif

/* rtl/rscc_pkg.sv */
// types shared by the clock ratio configuration block
package rscc_pkg;
    typedef logic [4:0] rscc_plat_code_t;   // platform ratio strap code
    typedef logic [3:0] rscc_core_code_t;   // core ratio strap code
    typedef enum logic [1:0] {
        RSCC_WAIT   = 2'b00,                 // reset released, settling
        RSCC_SAMPLE = 2'b01,                 // capture straps this cycle
        RSCC_RUN    = 2'b10                  // ratios frozen
    } rscc_state_e;
endpackage : rscc_pkg

/* rtl/rscc_ratio_decode.sv */
// strap code to ratio decoder for platform and core multipliers
`timescale 1ns/10ps
`default_nettype none
module rscc_ratio_decode
    import rscc_pkg::*;
(
    input  wire rscc_plat_code_t plat_code_in,   // platform strap code
    input  wire rscc_core_code_t core_code_in,   // core strap code
    output logic [4:0]           plat_mult_out,  // platform:reference
    output logic                 plat_err_out,   // reserved platform code
    output logic [3:0]           core_half_out,  // core:platform, halves
    output logic                 core_err_out    // reserved core code
);
    // platform code value is the multiplier itself when legal
    always_comb begin
        plat_mult_out = 5'h00;
        plat_err_out  = 1'b1;
        case (plat_code_in)
            5'h00, 5'h01, 5'h0B, 5'h0D: begin   // reserved holes
                plat_err_out = 1'b1;
            end
            default: begin
                if (plat_code_in <= 5'h12) begin   // 2..18 legal
                    plat_mult_out = plat_code_in;
                    plat_err_out  = 1'b0;
                end
            end
        endcase
    end

    // core ratio is kept in halves so 2.5 and 4.5 stay exact
    always_comb begin
        core_half_out = 4'h0;
        core_err_out  = 1'b0;
        case (core_code_in)
            4'h8:    core_half_out = 4'h4;   // 2:1
            4'hA:    core_half_out = 4'h5;   // 2.5:1
            4'hC:    core_half_out = 4'h6;   // 3:1
            4'hE:    core_half_out = 4'h7;   // 3.5:1
            4'h0:    core_half_out = 4'h8;   // 4:1
            4'h2:    core_half_out = 4'h9;   // 4.5:1
            default: core_err_out  = 1'b1;   // reserved
        endcase
    end
endmodule : rscc_ratio_decode
`default_nettype wire

/* rtl/rscc_top.sv */
// strap-captured clock ratio configuration with AXI4-Lite registers
//
// Notes on behaviour
// - platform clock is the system bus clock
// - capture five-bit platform strap after reset
// - platform code value is multiplier; holes reserved
// - capture four-bit core strap after reset
// - core codes decode to six fixed ratios
// - platform clock window 333 to 533 MHz
// - core clock at least 666, grade maximum; the window check uses a fixed 1333 whatever the speed strap
// - memory clock is half the platform clock
// - local clock is platform over software divider
`timescale 1ns/10ps
`default_nettype none
`include "rscc_params.svh"
module rscc_top
    import rscc_pkg::*;
(
    input  wire logic        CLK_SYS_IN,          // block clock, 20 MHz
    input  wire logic        NRST_IN,             // async reset, low
    input  wire logic [4:0]  PLAT_STRAP_IN,       // platform ratio straps
    input  wire logic [3:0]  CORE_STRAP_IN,       // core ratio straps
    input  wire logic        CORE_SPEED_STRAP_IN, // core speed strap
    input  wire logic [15:0] REF_CLK_MHZ_IN,      // reference clock, MHz
    output logic [4:0]       PLAT_MULT_OUT,       // platform multiplier
    output logic [3:0]       CORE_HALF_OUT,       // core ratio in halves
    output logic [7:0]       LCL_DIV_OUT,         // local clock divider
    output logic             CFG_VALID_OUT,       // ratios captured
    output logic             CFG_ERR_OUT,         // reserved code seen
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY
);
    localparam logic [2:0] SETTLE = 3'(`RSCC_SETTLE_CYC);

    ////////////////////////////////////////////////////////////////////
    // strap capture
    rscc_state_e     state;          // capture sequencer
    rscc_state_e     next_state;
    logic [2:0]      settle;         // settle counter
    logic [2:0]      next_settle;
    rscc_plat_code_t plat_code;      // captured platform code
    rscc_plat_code_t next_plat_code;
    rscc_core_code_t core_code;      // captured core code
    rscc_core_code_t next_core_code;
    logic            speed;          // captured speed strap
    logic            next_speed;
    logic [4:0]      dec_mult;       // decoder outputs
    logic            dec_perr;
    logic [3:0]      dec_half;
    logic            dec_cerr;

    // straps are read once after reset settles, never again; there is
    // no default ratio, so undriven straps give whatever they float to
    always_comb begin
        next_state     = state;
        next_settle    = settle;
        next_plat_code = plat_code;
        next_core_code = core_code;
        next_speed     = speed;
        case (state)
            RSCC_WAIT: begin
                if (settle >= SETTLE - 3'h1) begin
                    next_state = RSCC_SAMPLE;
                end else begin
                    next_settle = settle + 3'h1;
                end
            end
            RSCC_SAMPLE: begin
                next_plat_code = PLAT_STRAP_IN;
                next_core_code = CORE_STRAP_IN;
                next_speed     = CORE_SPEED_STRAP_IN;
                next_state     = RSCC_RUN;
            end
            RSCC_RUN: begin
                next_state = RSCC_RUN;   // frozen until next reset
            end
            default: begin
                next_state = RSCC_WAIT;
            end
        endcase
    end

    // capture registers take constants only under reset
    always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            state     <= RSCC_WAIT;
            settle    <= 3'h0;
            plat_code <= 5'h00;
            core_code <= 4'h0;
            speed     <= 1'b0;
        end else begin
            state     <= next_state;
            settle    <= next_settle;
            plat_code <= next_plat_code;
            core_code <= next_core_code;
            speed     <= next_speed;
        end
    end

    // shared ratio decoder
    rscc_ratio_decode u_dec (
        .plat_code_in  (plat_code),
        .core_code_in  (core_code),
        .plat_mult_out (dec_mult),
        .plat_err_out  (dec_perr),
        .core_half_out (dec_half),
        .core_err_out  (dec_cerr)
    );

    ////////////////////////////////////////////////////////////////////
    // frequency arithmetic and window checks
    logic [15:0] plat_mhz;   // platform = bus clock
    logic [15:0] core_mhz;   // core clock
    logic [15:0] mem_mhz;    // memory clock
    logic [15:0] lbc_mhz;    // local bus clock
    logic [7:0]  ldiv;       // software divider
    logic [7:0]  next_ldiv;
    logic [3:0]  limit_ok;   // plat, core, mem, local in window
    logic        cfg_err;    // reserved code after capture

    // true when a value lies inside [lo, hi]
    function automatic logic in_win(input logic [15:0] v,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
        in_win = (v >= lo) && (v <= hi);
    endfunction : in_win

    // platform follows the strap ratio on the reference
    assign plat_mhz = 16'(REF_CLK_MHZ_IN * {11'h000, dec_mult});
    // core ratio is in halves, so multiply then halve
    assign core_mhz = 16'((plat_mhz * {12'h000, dec_half}) >> 1);
    assign mem_mhz  = plat_mhz >> 1;
    // a zero divider would divide by zero, so it counts as one
    assign lbc_mhz  = plat_mhz / ((ldiv == 8'h00) ? 16'h0001
                                                   : {8'h00, ldiv});

    // the checks only flag; the board owns frequency choice
    always_comb begin
        limit_ok[0] = in_win(plat_mhz, `RSCC_PLAT_MIN_MHZ,
                             `RSCC_PLAT_MAX_MHZ);
        limit_ok[1] = in_win(core_mhz, `RSCC_CORE_MIN_MHZ,
                             `RSCC_CORE_MAX_MHZ);
        limit_ok[2] = in_win(mem_mhz, `RSCC_MEM_MIN_MHZ,
                             `RSCC_MEM_MAX_MHZ);
        limit_ok[3] = in_win(lbc_mhz, `RSCC_LBC_MIN_MHZ,
                             `RSCC_LBC_MAX_MHZ);
    end

    assign cfg_err = (state == RSCC_RUN) && (dec_perr || dec_cerr);

    // outputs registered; a ratio reads zero while its own code is reserved
    always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            PLAT_MULT_OUT <= 5'h00;
            CORE_HALF_OUT <= 4'h0;
            LCL_DIV_OUT   <= `RSCC_LDIV_RST;
            CFG_VALID_OUT <= 1'b0;
            CFG_ERR_OUT   <= 1'b0;
        end else begin
            PLAT_MULT_OUT <= dec_mult;
            CORE_HALF_OUT <= dec_half;
            LCL_DIV_OUT   <= ldiv;
            CFG_VALID_OUT <= (state == RSCC_RUN) && !cfg_err;
            CFG_ERR_OUT   <= cfg_err;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave
    logic        aw_hold, next_aw_hold;   // write address taken
    logic [7:0]  aw_addr, next_aw_addr;
    logic        w_hold, next_w_hold;     // write data taken
    logic [31:0] w_data, next_w_data;
    logic [3:0]  w_strb, next_w_strb;
    logic        bvalid, next_bvalid;
    logic [1:0]  bresp, next_bresp;
    logic        rvalid, next_rvalid;
    logic [31:0] rdata, next_rdata;
    logic [1:0]  rresp, next_rresp;
    logic [31:0] rd_word;
    logic        rd_hit;

    // read decode; unmapped addresses answer SLVERR with zero data
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        case (S_AXI_ARADDR)
            `RSCC_OFS_STATUS: begin
                rd_word[`RSCC_ST_CAPTURED] = (state == RSCC_RUN);
                rd_word[`RSCC_ST_PLAT_ERR] = cfg_err && dec_perr;
                rd_word[`RSCC_ST_CORE_ERR] = cfg_err && dec_cerr;
                rd_word[`RSCC_ST_SPEED]    = speed;
                rd_word[7:4]               = limit_ok;
            end
            `RSCC_OFS_PLAT: rd_word = {11'h000, plat_code, 11'h000, dec_mult};
            `RSCC_OFS_CORE: rd_word = {12'h000, core_code, 12'h000, dec_half};
            `RSCC_OFS_LDIV:      rd_word = {24'h00_0000, ldiv};
            `RSCC_OFS_LIMIT_PLT: rd_word = {mem_mhz, plat_mhz};
            `RSCC_OFS_LIMIT_CPU: rd_word = {16'h0000, core_mhz};
            `RSCC_OFS_LIMIT_LBC: rd_word = {16'h0000, lbc_mhz};
            default:             rd_hit  = 1'b0;
        endcase
    end

    // ready only while the matching half is not yet held
    assign S_AXI_AWREADY = !aw_hold && !bvalid;
    assign S_AXI_WREADY  = !w_hold && !bvalid;
    assign S_AXI_ARREADY = !rvalid;

    // write path: collect both halves, then commit and respond
    always_comb begin
        next_aw_hold = aw_hold;
        next_aw_addr = aw_addr;
        next_w_hold  = w_hold;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = bvalid;
        next_bresp   = bresp;
        next_ldiv    = ldiv;
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            next_aw_hold = 1'b1;
            next_aw_addr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            next_w_hold = 1'b1;
            next_w_data = S_AXI_WDATA;
            next_w_strb = S_AXI_WSTRB;
        end
        if (aw_hold && w_hold) begin
            next_aw_hold = 1'b0;
            next_w_hold  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = `RSCC_OKAY;
            if (aw_addr == `RSCC_OFS_LDIV) begin
                if (w_strb[0]) begin
                    next_ldiv = w_data[7:0];   // steers local clock
                end
            end else if (aw_addr > `RSCC_OFS_LIMIT_LBC
                         || aw_addr[1:0] != 2'b00) begin
                next_bresp = `RSCC_SLVERR;   // unmapped
            end
        end
        if (bvalid && S_AXI_BREADY) begin
            next_bvalid = 1'b0;
        end
    end

    // read path: one-cycle answer from the decode above
    always_comb begin
        next_rvalid = rvalid;
        next_rdata  = rdata;
        next_rresp  = rresp;
        if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            next_rvalid = 1'b1;
            next_rdata  = rd_word;
            next_rresp  = rd_hit ? `RSCC_OKAY : `RSCC_SLVERR;
        end else if (rvalid && S_AXI_RREADY) begin
            next_rvalid = 1'b0;
        end
    end

    // bus state registers
    always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            aw_hold <= 1'b0;
            aw_addr <= 8'h00;
            w_hold  <= 1'b0;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
            bvalid  <= 1'b0;
            bresp   <= `RSCC_OKAY;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= `RSCC_OKAY;
            ldiv    <= `RSCC_LDIV_RST;
        end else begin
            aw_hold <= next_aw_hold;
            aw_addr <= next_aw_addr;
            w_hold  <= next_w_hold;
            w_data  <= next_w_data;
            w_strb  <= next_w_strb;
            bvalid  <= next_bvalid;
            bresp   <= next_bresp;
            rvalid  <= next_rvalid;
            rdata   <= next_rdata;
            rresp   <= next_rresp;
            ldiv    <= next_ldiv;
        end
    end

    assign S_AXI_BVALID = bvalid;
    assign S_AXI_BRESP  = bresp;
    assign S_AXI_RVALID = rvalid;
    assign S_AXI_RDATA  = rdata;
    assign S_AXI_RRESP  = rresp;
endmodule : rscc_top
`default_nettype wire

/* test/rscc_checker.sv */
// concurrent checks on the ports of the clock ratio configuration top
`timescale 1ns/10ps
`default_nettype none
module rscc_checker (
    input wire logic        CLK_SYS_IN,
    input wire logic        NRST_IN,
    input wire logic [4:0]  PLAT_MULT_OUT,
    input wire logic [3:0]  CORE_HALF_OUT,
    input wire logic        CFG_VALID_OUT,
    input wire logic        CFG_ERR_OUT,
    input wire logic        S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY,
    input wire logic        S_AXI_RVALID,
    input wire logic        S_AXI_RREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_BREADY,
    input wire logic [1:0]  S_AXI_BRESP
);
    default clocking @(posedge CLK_SYS_IN); endclocking
    default disable iff (!NRST_IN);
    ////////////////////////////////////////////////////////////////////////
    logic [3:0] since_rst;      // edges since reset release, saturating
    logic [3:0] next_since_rst; // next count
    // saturate so the count never wraps back into the early window
    always_comb begin
        next_since_rst = (since_rst == 4'hF) ? since_rst : since_rst + 4'h1;
    end
    always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            since_rst <= 4'h0;
        end else begin
            since_rst <= next_since_rst;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    sequence s_rd_taken;
        S_AXI_ARVALID && S_AXI_ARREADY;
    endsequence
    sequence s_captured;
        CFG_VALID_OUT || CFG_ERR_OUT;
    endsequence
    a_cfg_exclusive: assert property (!(CFG_VALID_OUT && CFG_ERR_OUT))
        else $error("valid and error flags both high");
    a_err_zeroes: assert property (CFG_ERR_OUT |->
        (PLAT_MULT_OUT == 5'h00 || CORE_HALF_OUT == 4'h0))
        else $error("error flag with both ratios nonzero");
    a_plat_legal: assert property (CFG_VALID_OUT |->
        PLAT_MULT_OUT inside {[5'h02:5'h0A], 5'h0C, [5'h0E:5'h12]})
        else $error("platform multiplier outside legal set");
    a_core_legal: assert property (CFG_VALID_OUT |->
        CORE_HALF_OUT inside {[4'h4:4'h9]})
        else $error("core ratio outside legal set");
    a_capture_frozen: assert property ((CFG_VALID_OUT || CFG_ERR_OUT) &&
        ($past(CFG_VALID_OUT) || $past(CFG_ERR_OUT)) |->
        $stable(PLAT_MULT_OUT) && $stable(CORE_HALF_OUT))
        else $error("captured ratio changed");
    a_capture_by: assert property (since_rst == 4'hA |-> s_captured)
        else $error("straps not captured in time");
    a_no_early: assert property (since_rst < 4'h5 |-> not s_captured)
        else $error("capture flag before settle time");
    a_rd_answer: assert property (s_rd_taken |=> S_AXI_RVALID)
        else $error("read answer late");
    a_rd_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
        S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read answer dropped");
    a_wr_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
        S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write answer dropped");
endmodule : rscc_checker
bind rscc_top rscc_checker chk (.CLK_SYS_IN, .NRST_IN, .PLAT_MULT_OUT,
    .CORE_HALF_OUT, .CFG_VALID_OUT, .CFG_ERR_OUT, .S_AXI_ARVALID,
    .S_AXI_ARREADY, .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_RDATA,
    .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_BRESP);
`default_nettype wire

/* test/rscc_strap_model.sv */
// board strap resistor model feeding the ratio configuration block
`timescale 1ns/10ps
`default_nettype none
module rscc_strap_model (
    input  wire logic [4:0]  plat_code_in,    // wanted platform code
    input  wire logic [3:0]  core_code_in,    // wanted core code
    input  wire logic [15:0] ref_mhz_in,      // reference frequency
    input  wire logic        want_fast_in,    // ask for the speed strap
    output logic [4:0]       plat_strap_out,  // platform strap pins
    output logic [3:0]       core_strap_out,  // core strap pins
    output logic             speed_strap_out, // speed strap pin
    output logic [15:0]      ref_mhz_out      // reference frequency
);
    logic [3:0]  halves;   // core ratio in halves
    logic [31:0] core_mhz; // resulting core frequency
    // resistors always set a defined level, never left floating
    assign plat_strap_out = plat_code_in;
    assign core_strap_out = core_code_in;
    assign ref_mhz_out    = ref_mhz_in;
    // a slow part keeps the speed strap pulled low whatever is asked
    always_comb begin
        case (core_code_in)
            4'h8:    halves = 4'h4;
            4'hA:    halves = 4'h5;
            4'hC:    halves = 4'h6;
            4'hE:    halves = 4'h7;
            4'h0:    halves = 4'h8;
            4'h2:    halves = 4'h9;
            default: halves = 4'h0;
        endcase
        core_mhz = 32'(ref_mhz_in) * 32'(plat_code_in) * 32'(halves) / 32'h2;
        speed_strap_out = want_fast_in && (core_mhz > 32'h320);
    end
endmodule : rscc_strap_model
`default_nettype wire

/* test/tb_reset_strap_clock_ratio_config.sv */
// self-checking bench for the clock ratio configuration block
`timescale 1ns/10ps
`default_nettype none
module tb_reset_strap_clock_ratio_config;
    logic clk = 1'b0, nrst = 1'b0, fast = 1'b0;  // clock, reset, speed ask
    logic [4:0]  pc = 5'h00, plat_s, mult, em;   // platform code side
    logic [3:0]  cc = 4'h0, core_s, half, eh;    // core code side
    logic [15:0] ref_mhz = 16'h0028, ref_s, pm;  // 40 MHz reference
    logic        speed_s, vld, err;
    logic [7:0]  ldiv, es, awaddr = 8'h00, araddr = 8'h00;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, r;
    int          fails = 0, total_checks = 0, i;
    always #25 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    rscc_strap_model board (.plat_code_in(pc), .core_code_in(cc),
        .ref_mhz_in(ref_mhz), .want_fast_in(fast), .plat_strap_out(plat_s),
        .core_strap_out(core_s), .speed_strap_out(speed_s),
        .ref_mhz_out(ref_s));
    rscc_top dut (.CLK_SYS_IN(clk), .NRST_IN(nrst), .PLAT_STRAP_IN(plat_s),
        .CORE_STRAP_IN(core_s), .CORE_SPEED_STRAP_IN(speed_s),
        .REF_CLK_MHZ_IN(ref_s), .PLAT_MULT_OUT(mult), .CORE_HALF_OUT(half),
        .LCL_DIV_OUT(ldiv), .CFG_VALID_OUT(vld), .CFG_ERR_OUT(err),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready));
    ////////////////////////////////////////////////////////////////////////
    task chk(input string what, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task summarize;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize
    // ready is raised only once the answer shows, so the slave must hold it
    task axi_wr(input logic [7:0] a, input logic [31:0] v);
        int n;
        logic aw_t, w_t, b_t, b_v;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= v;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(negedge clk);
            aw_t = awvalid && awready;
            w_t  = wvalid && wready;
            b_t  = bvalid && bready;
            r    = bresp;
            b_v  = bvalid;   // mid-cycle view, no race with the edge
            @(posedge clk);
            if (aw_t) awvalid <= 1'b0;
            if (w_t) wvalid <= 1'b0;
            if (b_v && !bready) bready <= 1'b1;
            if (b_t) begin
                bready <= 1'b0;
                n = 1000;
            end
        end
        if (n == 100) begin
            chk("write_done", 32'h0, 32'h1);
            summarize();
        end
    endtask : axi_wr
    task axi_rd(input logic [7:0] a);
        int n;
        logic ar_t, r_t, r_v;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(negedge clk);
            ar_t = arvalid && arready;
            r_t  = rvalid && rready;
            d    = rdata;
            r    = rresp;
            r_v  = rvalid;   // mid-cycle view, no race with the edge
            @(posedge clk);
            if (ar_t) arvalid <= 1'b0;
            if (r_v && !rready) rready <= 1'b1;
            if (r_t) begin
                rready <= 1'b0;
                n = 1000;
            end
        end
        if (n == 100) begin
            chk("read_done", 32'h0, 32'h1);
            summarize();
        end
    endtask : axi_rd
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [3:0] exp_half(input logic [3:0] c);
        case (c)
            4'h8:    return 4'h4;
            4'hA:    return 4'h5;
            4'hC:    return 4'h6;
            4'hE:    return 4'h7;
            4'h0:    return 4'h8;
            4'h2:    return 4'h9;
            default: return 4'h0;
        endcase
    endfunction : exp_half
    initial begin
        repeat (20) @(posedge clk);
        // platform codes 0 to 19, core code from their low four bits, each under its own reset
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            nrst <= 1'b0;
            pc   <= i[4:0];
            cc   <= i[3:0];
            fast <= i[0];
            repeat (2) @(posedge clk);
            nrst <= 1'b1;
            repeat (12) @(posedge clk);
            @(negedge clk);
            em = (pc inside {[5'h02:5'h0A], 5'h0C, [5'h0E:5'h12]}) ? pc : 5'h0;
            eh = exp_half(cc);
            pm = ref_mhz * 16'(em);
            chk("plat_mult", 32'(mult), 32'(em));
            chk("core_half", 32'(half), 32'(eh));
            chk("cfg_err", 32'(err), 32'(em == 5'h0 || eh == 4'h0));
            chk("cfg_valid", 32'(vld), 32'(em != 5'h0 && eh != 4'h0));
            axi_rd(8'h04);
            chk("plat_reg", d, {11'h0, pc, 11'h0, em});
            axi_rd(8'h08);
            chk("core_reg", d, {12'h0, cc, 12'h0, eh});
            axi_rd(8'h00);
            chk("speed_bit", 32'(d[3]), 32'(speed_s));
            // window flags from the rule limits, divider at its reset of 4
            es[7:4] = {((pm >> 2) inside {[16'h0016:16'h0085]}),
                       ((pm >> 1) inside {[16'h00A6:16'h010A]}),
                       (((pm * 16'(eh)) >> 1) inside {[16'h029A:16'h0535]}),
                       (pm inside {[16'h014D:16'h0215]})};
            es[3:0] = {speed_s, eh == 4'h0, em == 5'h0, 1'b1};
            chk("status", 32'(d[7:0]), 32'(es));
            if (em != 5'h0) begin
                axi_rd(8'h10);
                chk("mem_plat_mhz", d, {pm >> 1, pm});
                axi_rd(8'h14);
                chk("core_mhz", d, {16'h0, (pm * 16'(eh)) >> 1});
                axi_rd(8'h18);
                chk("lbc_div4", d, {16'h0, pm >> 2});
                axi_wr(8'h0C, 32'h0000_0002);
                axi_rd(8'h18);
                chk("lbc_div2", d, {16'h0, pm >> 1});
            end
        end
        $display("test straps done");
        // straps move after capture; the captured code must not follow
        pc <= 5'h03;
        axi_rd(8'h0C);
        chk("ldiv_reset", d, 32'h4);
        chk("ldiv_out_reset", 32'(ldiv), 32'h4);
        axi_wr(8'h0C, 32'h0000_0008);
        chk("ldiv_wr_resp", 32'(r), 32'h0);
        axi_rd(8'h0C);
        chk("ldiv_back", d, 32'h8);
        chk("ldiv_out", 32'(ldiv), 32'h8);
        axi_wr(8'h04, 32'hFFFF_FFFF);
        chk("ro_wr_resp", 32'(r), 32'h0);
        axi_rd(8'h04);
        chk("ro_unchanged", d, 32'h0013_0000);
        chk("no_resample", 32'(mult), 32'h0);
        axi_wr(8'h1C, 32'h1);
        chk("unmapped_wr", 32'(r), 32'h2);
        axi_rd(8'h06);
        chk("misaligned_rd", {d[29:0], r}, 32'h2);
        $display("test regs done");
        summarize();
    end
endmodule : tb_reset_strap_clock_ratio_config
`default_nettype wire
